// *** design/scd_pkg.sv ***
// What this block does
// - Message: source, target, opcode, then data bytes
// - Unit address held, limited to 0x00-0x79
// - Act only when target equals unit address
// - Index ranges checked per resource kind
// - All resource indices count from zero
// - Exact data count per opcode; 0x01 no-op
// - Set, clear, invert output/flag; report flag bank
// - Blink with period, pulse with duration
// - Start, stop, pause, reset a sequence
// - Set lighting channel, lower or upper group
// - Ramp lighting, 16-bit or 8-bit duration
// - Analog set and ramp share lighting forms
// - Display: length then that many characters
// - Forward message bytes out of indexed port
// - Report variable out of port, optionally formatted
// - Copy local variable to remote unit variable
package scd_pkg;
  localparam logic [7:0] UNIT_ADDR_MAX = 8'h79;
  localparam logic [7:0] HOST_SRC_ADDR = 8'hff;
  localparam logic [7:0] OP_NOP = 8'h01;
  localparam logic [7:0] OP_ON = 8'h02;
  localparam logic [7:0] OP_OFF = 8'h03;
  localparam logic [7:0] OP_BLINK = 8'h04;
  localparam logic [7:0] OP_PULSE = 8'h05;
  localparam logic [7:0] OP_TOGGLE = 8'h06;
  localparam logic [7:0] OP_LEVEL_SET = 8'h07;
  localparam logic [7:0] OP_RAMP16_LO = 8'h08;
  localparam logic [7:0] OP_RAMP8 = 8'h09;
  localparam logic [7:0] OP_DISPLAY = 8'h0c;
  localparam logic [7:0] OP_FORWARD = 8'h0d;
  localparam logic [7:0] OP_VAR_REPORT = 8'h13;
  localparam logic [7:0] OP_VAR_REPORT_FMT = 8'h14;
  localparam logic [7:0] OP_REMOTE_WRITE = 8'h15;
  localparam logic [7:0] OP_SEQ_START = 8'h18;
  localparam logic [7:0] OP_SEQ_STOP = 8'h19;
  localparam logic [7:0] OP_SEQ_PAUSE = 8'h1a;
  localparam logic [7:0] OP_SEQ_RESET = 8'h1b;
  localparam logic [7:0] OP_FLAG_REPORT = 8'h1c;
  localparam logic [7:0] OP_HI_SET = 8'h1d;
  localparam logic [7:0] OP_RAMP16_HI = 8'h1e;
  localparam logic [7:0] OUTFLAG_MAX = 8'h7f;
  localparam logic [7:0] OUTPUT_MAX = 8'h3f;
  localparam logic [7:0] VAR_MAX = 8'h1f;
  localparam logic [7:0] PORT_MAX = 8'h11;
  localparam logic [7:0] BANK_MAX = 8'h01;
  localparam logic [7:0] UNIT_ADDR_RESET = 8'h00;

  typedef enum logic [4:0] {
    SCD_CMD_NOP, SCD_CMD_ON, SCD_CMD_OFF, SCD_CMD_TOGGLE, SCD_CMD_BLINK, SCD_CMD_PULSE,
    SCD_CMD_LIGHT_SET, SCD_CMD_LIGHT_RAMP, SCD_CMD_ANALOG_SET, SCD_CMD_ANALOG_RAMP,
    SCD_CMD_VAR_REPORT, SCD_CMD_VAR_REPORT_FMT, SCD_CMD_REMOTE_WRITE,
    SCD_CMD_SEQ_START, SCD_CMD_SEQ_STOP, SCD_CMD_SEQ_PAUSE, SCD_CMD_SEQ_RESET, SCD_CMD_FLAG_REPORT
  } scd_cmd_type;

  // One decoded action; unused fields are zero
  typedef struct packed {
    scd_cmd_type cmd;
    logic [7:0] index;
    logic [8:0] channel;
    logic [7:0] value;
    logic [15:0] frames;
    logic [7:0] extra;
    logic [7:0] src;
  } scd_action_type;

  // Streamed byte of a display or forward message
  typedef struct packed {
    logic to_display;
    logic [7:0] port;
    logic [7:0] data;
    logic last;
  } scd_stream_type;
endpackage

// *** design/scd_show_command_decoder.sv ***
`timescale 1ns/1ps
module scd_show_command_decoder
  import scd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Configuration
  input wire logic [7:0] unit_addr,
  input wire logic unit_addr_load,
  // Received bytes from the serial receiver
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic rx_msg_start,
  // Decoded action
  output scd_action_type action,
  output logic action_valid,
  // Streamed message bytes
  output scd_stream_type stream,
  output logic stream_valid,
  // Status
  output logic [7:0] unit_addr_q,
  output logic discard_pulse
);

  typedef enum logic [2:0] {ST_SRC, ST_TGT, ST_OP, ST_DATA, ST_LEN, ST_STREAM, ST_SKIP} scd_state_type;

  scd_state_type state_reg;
  logic [7:0] unit_reg;
  logic [7:0] src_reg;
  logic [7:0] op_reg;
  logic [7:0] d_reg [0:3];
  logic [2:0] cnt_reg;
  logic [7:0] len_reg;
  logic [7:0] port_reg;
  logic for_us_reg;
  logic bad_reg;
  scd_action_type action_reg;
  logic action_valid_reg;
  scd_stream_type stream_reg;
  logic stream_valid_reg;
  logic discard_reg;

  // Fixed data byte count per opcode; 7 marks unknown
  function automatic logic [2:0] data_count(input logic [7:0] op);
    unique case (op)
      OP_NOP: data_count = 3'd0;
      OP_ON, OP_OFF, OP_TOGGLE, OP_FLAG_REPORT, OP_SEQ_START, OP_SEQ_STOP, OP_SEQ_PAUSE, OP_SEQ_RESET:
        data_count = 3'd1;
      OP_BLINK, OP_PULSE, OP_LEVEL_SET, OP_HI_SET, OP_VAR_REPORT: data_count = 3'd2;
      OP_RAMP8, OP_VAR_REPORT_FMT, OP_REMOTE_WRITE: data_count = 3'd3;
      OP_RAMP16_LO, OP_RAMP16_HI: data_count = 3'd4;
      OP_DISPLAY, OP_FORWARD: data_count = 3'd0;
      default: data_count = 3'd7;
    endcase
  endfunction

  // Index byte range for the first data byte
  function automatic logic idx_ok(input logic [7:0] op, input logic [7:0] b);
    unique case (op)
      OP_ON, OP_OFF, OP_TOGGLE: idx_ok = (b <= OUTFLAG_MAX);
      OP_BLINK, OP_PULSE: idx_ok = (b <= OUTPUT_MAX);
      OP_FLAG_REPORT: idx_ok = (b <= BANK_MAX);
      OP_VAR_REPORT, OP_VAR_REPORT_FMT, OP_FORWARD: idx_ok = (b <= PORT_MAX);
      default: idx_ok = 1'b1;
    endcase
  endfunction

  // Unit address; a load above its legal range is ignored and the old value kept
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      unit_reg <= UNIT_ADDR_RESET;
    end else if (unit_addr_load && unit_addr <= UNIT_ADDR_MAX) begin
      unit_reg <= unit_addr;
    end
  end

  // Framing state machine
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg <= ST_SRC;
      src_reg <= 8'h00;
      op_reg <= 8'h00;
      cnt_reg <= 3'd0;
      len_reg <= 8'h00;
      port_reg <= 8'h00;
      for_us_reg <= 1'b0;
      bad_reg <= 1'b0;
      for (int i = 0; i < 4; i++) d_reg[i] <= 8'h00;
    end else if (rx_valid && rx_msg_start) begin
      // Address byte marks a new frame; a truncated frame is dropped
      src_reg <= rx_byte;
      state_reg <= ST_TGT;
    end else if (rx_valid) begin
      unique case (state_reg)
        ST_SRC: begin
          src_reg <= rx_byte;
          state_reg <= ST_TGT;
        end
        ST_TGT: begin
          for_us_reg <= (rx_byte == unit_reg);
          state_reg <= ST_OP;
        end
        ST_OP: begin
          op_reg <= rx_byte;
          cnt_reg <= 3'd0;
          bad_reg <= (data_count(rx_byte) == 3'd7);
          if (rx_byte == OP_DISPLAY) begin
            port_reg <= 8'h00;
            state_reg <= ST_LEN;
          end else if (rx_byte == OP_FORWARD) begin
            state_reg <= ST_DATA;
          end else if (data_count(rx_byte) == 3'd7) begin
            // Unknown length: swallow until next frame start
            state_reg <= ST_SKIP;
          end else if (data_count(rx_byte) == 3'd0) begin
            state_reg <= ST_SRC;
          end else begin
            state_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          d_reg[cnt_reg[1:0]] <= rx_byte;
          cnt_reg <= cnt_reg + 3'd1;
          if (cnt_reg == 3'd0 && !idx_ok(op_reg, rx_byte)) begin
            bad_reg <= 1'b1;
          end
          if (op_reg == OP_FORWARD) begin
            port_reg <= rx_byte;
            state_reg <= ST_LEN;
          end else if (cnt_reg + 3'd1 == data_count(op_reg)) begin
            state_reg <= ST_SRC;
          end
        end
        ST_LEN: begin
          len_reg <= rx_byte;
          state_reg <= (rx_byte == 8'h00) ? ST_SRC : ST_STREAM;
        end
        ST_STREAM: begin
          len_reg <= len_reg - 8'h01;
          if (len_reg == 8'h01) begin
            state_reg <= ST_SRC;
          end
        end
        ST_SKIP: state_reg <= ST_SKIP;
        default: state_reg <= ST_SRC;
      endcase
    end
  end

  // Last data byte of a fixed-length message completes it
  logic complete;
  assign complete = rx_valid && !rx_msg_start && state_reg == ST_DATA && op_reg != OP_FORWARD
                    && cnt_reg + 3'd1 == data_count(op_reg);

  // Variable indices checked at completion; bad ones are dropped
  logic var_bad;
  assign var_bad = (op_reg == OP_VAR_REPORT && rx_byte > VAR_MAX)
                || (op_reg == OP_VAR_REPORT_FMT && d_reg[1] > VAR_MAX)
                || (op_reg == OP_REMOTE_WRITE && (d_reg[1] > VAR_MAX || rx_byte > VAR_MAX));

  // Action dispatch
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      action_reg <= '0;
      action_valid_reg <= 1'b0;
    end else begin
      action_valid_reg <= 1'b0;
      if (complete && for_us_reg && !bad_reg && !var_bad
          && !(cnt_reg == 3'd0 && !idx_ok(op_reg, rx_byte))) begin
        action_valid_reg <= 1'b1;
        action_reg <= '0;
        action_reg.src <= src_reg;
        action_reg.index <= (cnt_reg == 3'd0) ? rx_byte : d_reg[0];
        unique case (op_reg)
          OP_ON: action_reg.cmd <= SCD_CMD_ON;
          OP_OFF: action_reg.cmd <= SCD_CMD_OFF;
          OP_TOGGLE: action_reg.cmd <= SCD_CMD_TOGGLE;
          OP_FLAG_REPORT: action_reg.cmd <= SCD_CMD_FLAG_REPORT;
          OP_BLINK, OP_PULSE: begin
            action_reg.cmd <= (op_reg == OP_BLINK) ? SCD_CMD_BLINK : SCD_CMD_PULSE;
            action_reg.frames <= {8'h00, rx_byte};
          end
          OP_SEQ_START: action_reg.cmd <= SCD_CMD_SEQ_START;
          OP_SEQ_STOP: action_reg.cmd <= SCD_CMD_SEQ_STOP;
          OP_SEQ_PAUSE: action_reg.cmd <= SCD_CMD_SEQ_PAUSE;
          OP_SEQ_RESET: action_reg.cmd <= SCD_CMD_SEQ_RESET;
          OP_LEVEL_SET, OP_HI_SET: begin
            // Lighting and analog share the opcode; the consumer routes both
            action_reg.cmd <= SCD_CMD_LIGHT_SET;
            // Lighting forms carry no resource index; the channel field holds it
            action_reg.index <= 8'h00;
            action_reg.channel <= {op_reg == OP_HI_SET, d_reg[0]};
            action_reg.value <= rx_byte;
          end
          OP_RAMP8: begin
            action_reg.cmd <= SCD_CMD_LIGHT_RAMP;
            action_reg.index <= 8'h00;
            action_reg.channel <= {1'b0, d_reg[0]};
            action_reg.value <= d_reg[1];
            action_reg.frames <= {8'h00, rx_byte};
          end
          OP_RAMP16_LO, OP_RAMP16_HI: begin
            action_reg.cmd <= SCD_CMD_LIGHT_RAMP;
            action_reg.index <= 8'h00;
            action_reg.channel <= {op_reg == OP_RAMP16_HI, d_reg[0]};
            action_reg.value <= d_reg[1];
            action_reg.frames <= {rx_byte, d_reg[2]};
          end
          OP_VAR_REPORT: begin
            action_reg.cmd <= SCD_CMD_VAR_REPORT;
            action_reg.value <= rx_byte;
          end
          OP_VAR_REPORT_FMT: begin
            action_reg.cmd <= SCD_CMD_VAR_REPORT_FMT;
            action_reg.value <= d_reg[1];
            action_reg.extra <= rx_byte;
          end
          OP_REMOTE_WRITE: begin
            action_reg.cmd <= SCD_CMD_REMOTE_WRITE;
            action_reg.value <= d_reg[1];
            action_reg.extra <= rx_byte;
          end
          default: action_reg.cmd <= SCD_CMD_NOP;
        endcase
      end
    end
  end

  // Stream output for display and forward payloads
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      stream_reg <= '0;
      stream_valid_reg <= 1'b0;
    end else begin
      stream_valid_reg <= 1'b0;
      if (rx_valid && !rx_msg_start && state_reg == ST_STREAM && for_us_reg && !bad_reg) begin
        stream_valid_reg <= 1'b1;
        stream_reg.to_display <= (op_reg == OP_DISPLAY);
        stream_reg.port <= port_reg;
        stream_reg.data <= rx_byte;
        stream_reg.last <= (len_reg == 8'h01);
      end
    end
  end

  // Discard indication for diagnostics
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      discard_reg <= 1'b0;
    end else begin
      discard_reg <= rx_valid && !rx_msg_start && for_us_reg
                  && ((state_reg == ST_OP && data_count(rx_byte) == 3'd7)
                  || (complete && (bad_reg || var_bad || (cnt_reg == 3'd0 && !idx_ok(op_reg, rx_byte)))));
    end
  end

  // Bad variable indices are caught before dispatch, so the valid stays a plain flop
  assign action = action_reg;
  assign action_valid = action_valid_reg;
  assign stream = stream_reg;
  assign stream_valid = stream_valid_reg;
  assign unit_addr_q = unit_reg;
  assign discard_pulse = discard_reg;

  AST_ADDR_RANGE: assert property (@(posedge sys_clk) disable iff (!rstn) unit_reg <= UNIT_ADDR_MAX)
    else $error("unit address out of range");
  AST_FOREIGN: assert property (@(posedge sys_clk) disable iff (!rstn)
    (complete && !for_us_reg) |=> !action_valid_reg)
    else $error("action for foreign target");
  AST_BAD_INDEX: assert property (@(posedge sys_clk) disable iff (!rstn)
    (complete && (op_reg == OP_ON || op_reg == OP_OFF || op_reg == OP_TOGGLE) && cnt_reg == 3'd0
    && rx_byte > OUTFLAG_MAX) |=> !action_valid_reg)
    else $error("out of range index acted on");
  AST_NOP_SILENT: assert property (@(posedge sys_clk) disable iff (!rstn)
    (rx_valid && !rx_msg_start && state_reg == ST_OP && rx_byte == OP_NOP) |=> state_reg == ST_SRC && !action_valid_reg)
    else $error("nop misframed");
  AST_ON_ACT: assert property (@(posedge sys_clk) disable iff (!rstn)
    (complete && for_us_reg && !bad_reg && op_reg == OP_ON && rx_byte <= OUTFLAG_MAX)
    |=> action_valid_reg && action_reg.cmd == SCD_CMD_ON && action_reg.index == $past(rx_byte))
    else $error("on not dispatched");
  AST_RAMP16: assert property (@(posedge sys_clk) disable iff (!rstn)
    (complete && for_us_reg && !bad_reg && op_reg == OP_RAMP16_HI)
    |=> action_reg.channel[8] && action_reg.frames[15:8] == $past(rx_byte))
    else $error("ramp duration misassembled");
  AST_SEQ: assert property (@(posedge sys_clk) disable iff (!rstn)
    (complete && for_us_reg && !bad_reg && op_reg == OP_SEQ_STOP) |=> action_reg.cmd == SCD_CMD_SEQ_STOP)
    else $error("sequence stop lost");
  AST_STREAM_LAST: assert property (@(posedge sys_clk) disable iff (!rstn)
    (stream_valid_reg && stream_reg.last) |-> state_reg == ST_SRC || state_reg == ST_TGT)
    else $error("stream ended off frame");
  AST_UNKNOWN: assert property (@(posedge sys_clk) disable iff (!rstn)
    (rx_valid && !rx_msg_start && state_reg == ST_OP && data_count(rx_byte) == 3'd7 && for_us_reg)
    |=> discard_reg && state_reg == ST_SKIP)
    else $error("unknown opcode not discarded");
  AST_VAR_RANGE: assert property (@(posedge sys_clk) disable iff (!rstn)
    (complete && var_bad) |=> !action_valid_reg)
    else $error("out of range variable acted on");
  AST_DISCARD_EXCL: assert property (@(posedge sys_clk) disable iff (!rstn)
    discard_reg |-> !action_valid_reg)
    else $error("discarded message also dispatched");
  AST_STREAM_DATA: assert property (@(posedge sys_clk) disable iff (!rstn)
    (rx_valid && !rx_msg_start && state_reg == ST_STREAM && for_us_reg && !bad_reg)
    |=> stream_valid_reg && stream_reg.data == $past(rx_byte))
    else $error("payload byte not streamed");
  AST_LIGHT_INDEX: assert property (@(posedge sys_clk) disable iff (!rstn)
    (complete && for_us_reg && !bad_reg && op_reg == OP_LEVEL_SET)
    |=> action_valid_reg && action_reg.index == 8'h00 && !action_reg.channel[8])
    else $error("lower group set misrouted");

endmodule

// *** verif/scd_host_model.sv ***
`timescale 1ns/1ps
module scd_host_model
  import scd_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Bytes toward the decoder, parity already stripped
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic rx_msg_start
);
  logic [7:0] msg_q[$];

  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    rx_msg_start = 1'b0;
  end

  // Frames source, target, then queued opcode and data; gap idles between bytes
  task automatic run(input logic [7:0] tgt, input int gap);
    msg_q.push_front(tgt);
    msg_q.push_front(HOST_SRC_ADDR);
    foreach (msg_q[i]) begin
      @(posedge sys_clk);
      rx_byte <= msg_q[i];
      rx_valid <= 1'b1;
      rx_msg_start <= (i == 0);
      if (gap > 0) begin
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_msg_start <= 1'b0;
        // Idle line shows junk, never a stale copy of the byte
        rx_byte <= ~msg_q[i];
        repeat (gap - 1) @(posedge sys_clk);
      end
    end
    if (gap == 0) begin
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      rx_msg_start <= 1'b0;
      rx_byte <= ~rx_byte;
    end
    msg_q.delete();
  endtask
endmodule

// *** verif/scd_show_command_decoder_bench.sv ***
`timescale 1ns/1ps
module scd_show_command_decoder_bench;
  import scd_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn, unit_addr_load, rx_valid, rx_msg_start, action_valid, stream_valid, discard_pulse;
  logic [7:0] unit_addr, rx_byte, unit_addr_q, unit, o, v, p, b, w;
  scd_action_type action;
  scd_stream_type stream;
  int mismatches = 0;
  int check_count = 0;
  int exp_disc = 0;
  integer seed = 32'h4722ad6a;
  scd_action_type exp_act_q[$];
  scd_stream_type exp_str_q[$];
  logic [7:0] bop[5] = '{OP_TOGGLE, OP_PULSE, OP_FLAG_REPORT, OP_VAR_REPORT, OP_VAR_REPORT_FMT};
  logic [7:0] ba[5] = '{8'h80, 8'h40, 8'h02, 8'h12, 8'h00};
  logic [7:0] bb[5] = '{8'h00, 8'h05, 8'h00, 8'h00, 8'h20};
  int bn[5] = '{1, 2, 1, 2, 3};

  scd_show_command_decoder scd_show_command_decoder_inst (.sys_clk(sys_clk), .rstn(rstn), .unit_addr(unit_addr),
    .unit_addr_load(unit_addr_load), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_msg_start(rx_msg_start),
    .action(action), .action_valid(action_valid), .stream(stream), .stream_valid(stream_valid),
    .unit_addr_q(unit_addr_q), .discard_pulse(discard_pulse));
  scd_host_model scd_host_model_inst (.sys_clk(sys_clk), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_msg_start(rx_msg_start));

  always #5 sys_clk = ~sys_clk;

  task automatic fail(input string m);
    mismatches++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic cmp_act(input scd_action_type e, input scd_action_type g);
    check_count++;
    if (g !== e) fail($sformatf("action %h, expected %h", g, e));
  endtask
  task automatic cmp_str(input scd_stream_type e, input scd_stream_type g);
    check_count++;
    if (g !== e) fail($sformatf("stream %h, expected %h", g, e));
  endtask
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) fail($sformatf("byte %h, expected %h", g, e));
  endtask
  task automatic exp_a(input scd_cmd_type c, input logic [7:0] i, input logic [8:0] ch, input logic [7:0] val,
                       input logic [15:0] fr, input logic [7:0] ex);
    exp_act_q.push_back('{c, i, ch, val, fr, ex, HOST_SRC_ADDR});
  endtask
  task automatic exp_s(input logic d, input logic [7:0] pt, input logic [7:0] dt, input logic l);
    exp_str_q.push_back('{d, pt, dt, l});
  endtask
  // Queues opcode and the first n data bytes, then sends with a random byte spacing
  task automatic msg(input logic [7:0] op, a, a2, a3, a4, input int n);
    logic [7:0] dv[4];
    dv = '{a, a2, a3, a4};
    scd_host_model_inst.msg_q.push_back(op);
    for (int i = 0; i < n; i++) begin
      scd_host_model_inst.msg_q.push_back(dv[i]);
    end
    scd_host_model_inst.run(unit, $unsigned($random(seed)) % 3);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic load(input logic [7:0] a);
    unit_addr <= a;
    unit_addr_load <= 1'b1;
    @(posedge sys_clk);
    unit_addr_load <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic print_verdict();
    check_count++;
    if (exp_act_q.size() != 0 || exp_str_q.size() != 0 || exp_disc != 0) fail("results missing");
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    if (rstn === 1'b1 && action_valid === 1'b1) begin
      if (exp_act_q.size() == 0) fail("unexpected action");
      else cmp_act(exp_act_q.pop_front(), action);
    end
    if (rstn === 1'b1 && stream_valid === 1'b1) begin
      if (exp_str_q.size() == 0) fail("unexpected stream byte");
      else cmp_str(exp_str_q.pop_front(), stream);
    end
    if (rstn === 1'b1 && discard_pulse === 1'b1) begin
      if (exp_disc > 0) exp_disc--;
      else fail("unexpected discard");
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail("timeout");
    print_verdict();
  end

  initial begin
    rstn = 1'b0;
    unit_addr = 8'h00;
    unit_addr_load = 1'b0;
    unit = 8'h00;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    #1;
    cmp_act('0, action);
    cmp_str('0, stream);
    cmp_byte(UNIT_ADDR_RESET, unit_addr_q);
    exp_a(SCD_CMD_ON, 8'h00, 9'h000, 8'h00, 16'h0000, 8'h00);
    msg(OP_ON, 8'h00, 8'h00, 8'h00, 8'h00, 1);
    unit = 8'h05;
    msg(OP_ON, 8'h01, 8'h00, 8'h00, 8'h00, 1);
    load(8'h79);
    cmp_byte(8'h79, unit_addr_q);
    load(8'h7a);
    cmp_byte(8'h79, unit_addr_q);
    unit = 8'h79;
    $display("test address done");
    for (int r = 0; r < 4; r++) begin
      o = 8'($random(seed)) & OUTFLAG_MAX;
      v = 8'($random(seed)) & VAR_MAX;
      p = 8'($unsigned($random(seed)) % 18);
      b = 8'($random(seed));
      w = 8'($random(seed));
      msg(OP_NOP, o, o, o, o, 0);
      exp_a(SCD_CMD_ON, o, 9'h000, 8'h00, 16'h0000, 8'h00);
      msg(OP_ON, o, 8'h00, 8'h00, 8'h00, 1);
      exp_a(SCD_CMD_OFF, o, 9'h000, 8'h00, 16'h0000, 8'h00);
      msg(OP_OFF, o, 8'h00, 8'h00, 8'h00, 1);
      exp_a(SCD_CMD_TOGGLE, o, 9'h000, 8'h00, 16'h0000, 8'h00);
      msg(OP_TOGGLE, o, 8'h00, 8'h00, 8'h00, 1);
      exp_a(SCD_CMD_BLINK, o & OUTPUT_MAX, 9'h000, 8'h00, {8'h00, b}, 8'h00);
      msg(OP_BLINK, o & OUTPUT_MAX, b, 8'h00, 8'h00, 2);
      exp_a(SCD_CMD_PULSE, o & OUTPUT_MAX, 9'h000, 8'h00, {8'h00, w}, 8'h00);
      msg(OP_PULSE, o & OUTPUT_MAX, w, 8'h00, 8'h00, 2);
      exp_a(SCD_CMD_LIGHT_SET, 8'h00, {1'b0, w}, b, 16'h0000, 8'h00);
      msg(OP_LEVEL_SET, w, b, 8'h00, 8'h00, 2);
      exp_a(SCD_CMD_LIGHT_SET, 8'h00, {1'b1, b}, w, 16'h0000, 8'h00);
      msg(OP_HI_SET, b, w, 8'h00, 8'h00, 2);
      exp_a(SCD_CMD_LIGHT_RAMP, 8'h00, {1'b0, w}, v, {o, b}, 8'h00);
      msg(OP_RAMP16_LO, w, v, b, o, 4);
      exp_a(SCD_CMD_LIGHT_RAMP, 8'h00, {1'b1, b}, o, {w, v}, 8'h00);
      msg(OP_RAMP16_HI, b, o, v, w, 4);
      exp_a(SCD_CMD_LIGHT_RAMP, 8'h00, {1'b0, o}, w, {8'h00, b}, 8'h00);
      msg(OP_RAMP8, o, w, b, 8'h00, 3);
      exp_a(SCD_CMD_VAR_REPORT, p, 9'h000, v, 16'h0000, 8'h00);
      msg(OP_VAR_REPORT, p, v, 8'h00, 8'h00, 2);
      exp_a(SCD_CMD_VAR_REPORT_FMT, p, 9'h000, v, 16'h0000, b);
      msg(OP_VAR_REPORT_FMT, p, v, b, 8'h00, 3);
      exp_a(SCD_CMD_REMOTE_WRITE, w, 9'h000, v, 16'h0000, o & VAR_MAX);
      msg(OP_REMOTE_WRITE, w, v, o & VAR_MAX, 8'h00, 3);
      exp_a(SCD_CMD_FLAG_REPORT, b & BANK_MAX, 9'h000, 8'h00, 16'h0000, 8'h00);
      msg(OP_FLAG_REPORT, b & BANK_MAX, 8'h00, 8'h00, 8'h00, 1);
      for (int k = 0; k < 4; k++) begin
        exp_a(scd_cmd_type'(SCD_CMD_SEQ_START + k), w, 9'h000, 8'h00, 16'h0000, 8'h00);
        msg(OP_SEQ_START + 8'(k), w, 8'h00, 8'h00, 8'h00, 1);
      end
      exp_s(1'b1, 8'h00, b, 1'b0);
      exp_s(1'b1, 8'h00, w, 1'b1);
      msg(OP_DISPLAY, 8'h02, b, w, 8'h00, 3);
      exp_s(1'b0, p, w, 1'b0);
      exp_s(1'b0, p, b, 1'b1);
      msg(OP_FORWARD, p, 8'h02, w, b, 4);
      msg(OP_FORWARD, p, 8'h00, 8'h00, 8'h00, 2);
    end
    $display("test commands done");
    for (int k = 0; k < 5; k++) begin
      exp_disc++;
      msg(bop[k], ba[k], bb[k], 8'h00, 8'h00, bn[k]);
    end
    $display("test range done");
    exp_disc++;
    msg(8'h0a, 8'h02, 8'h03, 8'h00, 8'h00, 2);
    exp_a(SCD_CMD_OFF, 8'h7f, 9'h000, 8'h00, 16'h0000, 8'h00);
    msg(OP_OFF, 8'h7f, 8'h00, 8'h00, 8'h00, 1);
    $display("test unknown opcode done");
    print_verdict();
  end
endmodule
